// >>> rtl/spi_dual_pkg.sv
package spi_dual_pkg;

  // Link timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_PERIOD_NS = 80;
  localparam int SCK_HALF_CYC  = (SCK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam logic [3:0] TMR_LOAD = 4'(SCK_HALF_CYC - 1);

  // One byte is sixteen serial clock edges
  localparam logic [3:0] EDGE_FIRST = 4'h0;
  localparam logic [3:0] EDGE_LAST  = 4'hF;

  // Control register fields
  localparam int CTL_CPOL = 0;
  localparam int CTL_CPHA = 1;
  localparam logic [1:0] CTL_RESET = 2'h0;
  localparam logic [3:0] SEL_RESET = 4'hF;

  // Configured flash target
  localparam logic [1:0] TGT_MIXED  = 2'h0;
  localparam logic [1:0] TGT_BASE   = 2'h1;
  localparam logic [1:0] TGT_SECOND = 2'h2;
  localparam logic [1:0] TGT_THIRD  = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CHECK = 6'h02,
    ST_SETUP = 6'h04,
    ST_SHIFT = 6'h08,
    ST_FETCH = 6'h10,
    ST_HOLD  = 6'h20
  } state_t;

  function automatic logic is_quad(input logic [7:0] op);
    unique case (op)
      8'h32, 8'h34, 8'h38, 8'h3E, 8'h6B, 8'h6C, 8'hEB, 8'hEC, 8'hE7, 8'hF5, 8'hAF: is_quad = 1'b1;
      default: is_quad = 1'b0;
    endcase
  endfunction : is_quad

  function automatic logic is_second_only(input logic [7:0] op);
    unique case (op)
      8'h28, 8'h29, 8'h2D, 8'h2C, 8'hC4: is_second_only = 1'b1;
      default: is_second_only = 1'b0;
    endcase
  endfunction : is_second_only

  function automatic logic is_third_only(input logic [7:0] op);
    unique case (op)
      8'h21, 8'h5C: is_third_only = 1'b1;
      default: is_third_only = 1'b0;
    endcase
  endfunction : is_third_only

  function automatic logic is_never(input logic [7:0] op);
    unique case (op)
      8'h96, 8'h9B, 8'hE1, 8'hFF: is_never = 1'b1;
      default: is_never = 1'b0;
    endcase
  endfunction : is_never

  // Command filter for the dual-lane build
  function automatic logic cmd_ok(input logic [7:0] op, input logic [1:0] tgt);
    logic ok;
    ok = !is_quad(op) && !is_never(op);
    unique case (tgt)
      TGT_MIXED, TGT_BASE: ok = ok && !is_second_only(op) && !is_third_only(op);
      TGT_SECOND:          ok = ok && !is_third_only(op);
      TGT_THIRD:           ok = ok && !is_second_only(op);
    endcase
    cmd_ok = ok;
  endfunction : cmd_ok

endpackage : spi_dual_pkg

// >>> rtl/spi_rx_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module spi_rx_buffer (
  input  wire logic       clk_i,       // System clock
  input  wire logic       nrst_i,      // Async reset, active low
  input  wire logic       clr_i,       // Local synchronous clear
  input  wire logic       in_valid_i,  // Word offered
  output logic            in_ready_o,  // Space for a word
  input  wire logic [7:0] in_data_i,   // Word in
  output logic            out_valid_o, // Word available
  input  wire logic       out_ready_i, // Drain accepts
  output logic [7:0]      out_data_o   // Word out
);

  logic [7:0] mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else if (clr_i) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (clr_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end

endmodule : spi_rx_buffer

`default_nettype wire

// >>> rtl/spi_dual_master.sv
`timescale 1ns/100ps
`default_nettype none

module spi_dual_master (
  input  wire logic       clk_i,         // 200 MHz system clock
  input  wire logic       nrst_i,        // Async reset, active low
  input  wire logic       soft_reset_i,  // Software reset pulse
  input  wire logic       cpol_i,        // Clock polarity, 1 idles high
  input  wire logic       cpha_i,        // Clock phase
  input  wire logic [1:0] target_type_i, // Configured flash target
  input  wire logic [3:0] sel_i,         // Slave select mask, 0 selects
  input  wire logic       cmd_valid_i,   // Command offered
  output logic            cmd_ready_o,   // Engine idle
  input  wire logic [7:0] cmd_opcode_i,  // Command opcode
  input  wire logic [3:0] cmd_len_i,     // Data bytes after opcode
  input  wire logic       tx_valid_i,    // Outgoing byte offered
  output logic            tx_ready_o,    // Outgoing byte taken
  input  wire logic [7:0] tx_data_i,     // Outgoing byte
  output logic            rx_valid_o,    // Received byte available
  input  wire logic       rx_ready_i,    // Received byte taken
  output logic [7:0]      rx_data_o,     // Received byte
  input  wire logic       err_clear_i,   // Clear command error
  output logic            cmd_err_o,     // Sticky command error
  output logic            busy_o,        // Frame in progress
  output logic            sck_o,         // Serial clock
  output logic [3:0]      ss_n_o,        // Slave selects, active low
  output logic            mosi_o,        // Serial data out
  input  wire logic       miso_i         // Serial data in
);

  spi_dual_pkg::state_t state;

  logic [1:0] serial_control_reg;
  logic [3:0] target_select_reg;
  logic [7:0] opcode;
  logic [3:0] bytes_left;
  logic [3:0] timer;
  logic [3:0] edge_cnt;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic       sck;
  logic       sel_active;
  logic       data_byte;
  logic       cmd_err;
  logic       miso_s1;
  logic       miso_s2;
  logic       rx_in_ready;
  logic       tick;
  logic       edge_now;
  logic       sample_edge;
  logic       shift_now;
  logic       byte_done;
  logic       rx_push;
  logic       accept;
  logic       reject;
  logic [7:0] rx_word;
  logic       cpha;

  assign cpha        = serial_control_reg[spi_dual_pkg::CTL_CPHA];
  assign cmd_ready_o = (state == spi_dual_pkg::ST_IDLE);
  assign accept      = cmd_valid_i && cmd_ready_o;
  assign reject      = (state == spi_dual_pkg::ST_CHECK) &&
                       !spi_dual_pkg::cmd_ok(opcode, target_type_i);
  assign tick        = (timer == 4'h0);
  assign edge_now    = (state == spi_dual_pkg::ST_SHIFT) && tick;
  // Even edges are leading edges; phase picks which kind samples
  assign sample_edge = edge_now && (edge_cnt[0] == cpha);
  assign shift_now   = edge_now && (edge_cnt[0] != cpha) &&
                       (edge_cnt != (cpha ? spi_dual_pkg::EDGE_FIRST : spi_dual_pkg::EDGE_LAST));
  assign byte_done   = edge_now && (edge_cnt == spi_dual_pkg::EDGE_LAST);
  assign rx_word     = sample_edge ? {rx_shift[6:0], miso_s2} : rx_shift;
  assign rx_push     = byte_done && data_byte;
  // Never start a data byte unless its answer has somewhere to go
  assign tx_ready_o  = (state == spi_dual_pkg::ST_FETCH) && rx_in_ready;
  assign busy_o      = !cmd_ready_o;
  assign sck_o       = sck;
  assign mosi_o      = tx_shift[7];
  assign ss_n_o      = sel_active ? target_select_reg : spi_dual_pkg::SEL_RESET;
  assign cmd_err_o   = cmd_err;

  // Data pin from the flash crosses into this domain
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
    end
  end

  // Mode and select captured per frame, so a change mid-frame is harmless
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_control_reg <= spi_dual_pkg::CTL_RESET;
      target_select_reg  <= spi_dual_pkg::SEL_RESET;
      opcode             <= 8'h00;
    end else if (soft_reset_i) begin
      serial_control_reg <= spi_dual_pkg::CTL_RESET;
      target_select_reg  <= spi_dual_pkg::SEL_RESET;
      opcode             <= 8'h00;
    end else if (accept) begin
      serial_control_reg <= {cpha_i, cpol_i};
      target_select_reg  <= sel_i;
      opcode             <= cmd_opcode_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_err <= 1'b0;
    end else if (soft_reset_i) begin
      cmd_err <= 1'b0;
    end else if (reject) begin
      cmd_err <= 1'b1;
    end else if (err_clear_i) begin
      cmd_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state      <= spi_dual_pkg::ST_IDLE;
      bytes_left <= 4'h0;
      timer      <= 4'h0;
      edge_cnt   <= 4'h0;
      sck        <= 1'b0;
      sel_active <= 1'b0;
      data_byte  <= 1'b0;
    end else if (soft_reset_i) begin
      state      <= spi_dual_pkg::ST_IDLE;
      bytes_left <= 4'h0;
      timer      <= 4'h0;
      edge_cnt   <= 4'h0;
      // Default polarity at once; the old one would move the clock a cycle later while deselected
      sck        <= spi_dual_pkg::CTL_RESET[spi_dual_pkg::CTL_CPOL];
      sel_active <= 1'b0;
      data_byte  <= 1'b0;
    end else begin
      if (!tick) timer <= timer - 4'h1;
      unique case (state)
        spi_dual_pkg::ST_IDLE: begin
          if (accept) begin
            sck        <= cpol_i;
            bytes_left <= cmd_len_i;
            data_byte  <= 1'b0;
            state      <= spi_dual_pkg::ST_CHECK;
          end else begin
            sck <= serial_control_reg[spi_dual_pkg::CTL_CPOL];
          end
        end
        spi_dual_pkg::ST_CHECK: begin
          if (reject) begin
            state <= spi_dual_pkg::ST_IDLE; // select never drops
          end else begin
            sel_active <= 1'b1;
            timer      <= spi_dual_pkg::TMR_LOAD;
            state      <= spi_dual_pkg::ST_SETUP;
          end
        end
        spi_dual_pkg::ST_SETUP: begin
          if (tick) begin
            timer    <= spi_dual_pkg::TMR_LOAD;
            edge_cnt <= spi_dual_pkg::EDGE_FIRST;
            state    <= spi_dual_pkg::ST_SHIFT;
          end
        end
        spi_dual_pkg::ST_SHIFT: begin
          if (tick) begin
            sck      <= ~sck;
            edge_cnt <= edge_cnt + 4'h1;
            timer    <= spi_dual_pkg::TMR_LOAD;
            if (byte_done) begin
              if (bytes_left == 4'h0) begin
                state <= spi_dual_pkg::ST_HOLD;
              end else begin
                state <= spi_dual_pkg::ST_FETCH;
              end
            end
          end
        end
        spi_dual_pkg::ST_FETCH: begin
          // Clock parks at idle while software or the drain side catches up
          if (tx_valid_i && rx_in_ready) begin
            bytes_left <= bytes_left - 4'h1;
            data_byte  <= 1'b1;
            timer      <= spi_dual_pkg::TMR_LOAD;
            state      <= spi_dual_pkg::ST_SETUP;
          end
        end
        spi_dual_pkg::ST_HOLD: begin
          if (tick) begin
            sel_active <= 1'b0;
            state      <= spi_dual_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
    end else if (soft_reset_i) begin
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
    end else begin
      if (state == spi_dual_pkg::ST_CHECK) tx_shift <= opcode;
      else if (tx_ready_o && tx_valid_i) tx_shift <= tx_data_i;
      else if (shift_now) tx_shift <= {tx_shift[6:0], 1'b0};
      if (sample_edge) rx_shift <= {rx_shift[6:0], miso_s2};
    end
  end

  spi_rx_buffer u_rx_buffer (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .clr_i       (soft_reset_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_word),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

endmodule : spi_dual_master

`default_nettype wire

// >>> dv/spi_dual_master_chk.sv
`timescale 1ns/100ps
`default_nettype none
module spi_dual_master_chk (
  input wire logic       clk_i,        // Clock
  input wire logic       nrst_i,       // Reset
  input wire logic       soft_reset_i, // Soft reset
  input wire logic       cpol_i,       // Polarity
  input wire logic       cpha_i,       // Phase
  input wire logic [3:0] sel_i,        // Select mask
  input wire logic       cmd_valid_i,  // Offer
  input wire logic       cmd_ready_o,  // Idle
  input wire logic       err_clear_i,  // Clear
  input wire logic       cmd_err_o,    // Error
  input wire logic       tx_ready_o,   // Tx taken
  input wire logic       rx_valid_o,   // Rx held
  input wire logic       rx_ready_i,   // Rx drain
  input wire logic       sck_o,        // Clock out
  input wire logic [3:0] ss_n_o        // Selects
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic cap_cpol;
  wire  hs    = cmd_valid_i && cmd_ready_o;
  wire  desel = &ss_n_o;
  // Idle level follows the polarity taken at the last accept, not the live input
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_cpol <= 1'b0;
    end else if (hs) begin
      cap_cpol <= cpol_i;
    end
  end
  property p_err_hold; cmd_err_o && !err_clear_i && !soft_reset_i |=> cmd_err_o; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
  property p_err_src; $rose(cmd_err_o) |-> ($past(hs, 2) || $past(hs, 3)) && desel && cmd_ready_o; endproperty
  a_err_src: assert property (p_err_src) else $error("error flag without refused command");
  property p_idle_desel; cmd_ready_o |-> desel; endproperty
  a_idle_desel: assert property (p_idle_desel) else $error("select low while idle");
  property p_check; hs |=> !cmd_ready_o && desel; endproperty
  a_check: assert property (p_check) else $error("select low during check");
  property p_setup; $fell(desel) |-> (sck_o == cap_cpol) [*8]; endproperty
  a_setup: assert property (p_setup) else $error("clock left idle too early");
  property p_half; $changed(sck_o) && !desel |=> $stable(sck_o) [*7]; endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_mask; $fell(desel) |-> ss_n_o == $past(sel_i, 2); endproperty
  a_mask: assert property (p_mask) else $error("select differs from mask");
  property p_end; $rose(desel) && !$past(soft_reset_i) |-> sck_o == cap_cpol; endproperty
  a_end: assert property (p_end) else $error("clock not idle at frame end");
  property p_sck_sel; $changed(sck_o) |-> !desel || $past(hs) || $past(hs, 2) || $past(soft_reset_i); endproperty
  a_sck_sel: assert property (p_sck_sel) else $error("clock moved while deselected");
  c_mode3: cover property (hs && cpha_i && cpol_i);
  c_reject: cover property ($rose(cmd_err_o));
  c_stall: cover property (rx_valid_o && !rx_ready_i && !tx_ready_o && !cmd_ready_o);
endmodule : spi_dual_master_chk
bind spi_dual_master spi_dual_master_chk i_chk (.*);
`default_nettype wire

// >>> dv/spi_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_flash_model (
  input  wire logic cpol_i, // Polarity expected
  input  wire logic cpha_i, // Phase expected
  input  wire logic sck_i,  // Serial clock
  input  wire logic ss_n_i, // Select, low active
  input  wire logic mosi_i, // From master
  output var  logic miso_o  // To master
);
  logic [7:0] in_sr;
  logic [7:0] out_sr;
  logic [7:0] last;
  logic [7:0] got[$];
  int         cnt;
  int         n_edges = 0;
  initial miso_o = 1'b0;
  // Echo each byte one byte later, so rx data proves both bit order and phase
  always @(negedge ss_n_i) begin
    cnt = 0;
    last = 8'h5A;
    out_sr = 8'h5A;
    miso_o = out_sr[7];
  end
  // A released line shows the inverse, so a stale bit never passes
  always @(posedge ss_n_i) miso_o = ~miso_o;
  always @(sck_i) begin
    if (!ss_n_i) begin
      n_edges++;
      if ((sck_i != cpol_i) ^ cpha_i) begin
        in_sr = {in_sr[6:0], mosi_i};
        cnt = (cnt + 1) % 8;
        if (cnt == 0) begin
          last = in_sr;
          got.push_back(in_sr);
        end
      end else begin
        out_sr = (cnt == 0) ? last : out_sr << 1;
        miso_o = out_sr[7];
      end
    end
  end
endmodule : spi_flash_model
`default_nettype wire

// >>> dv/spi_dual_master_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spi_dual_master_tb;
  logic clk_i = 1'b0, nrst_i = 1'b0, soft_reset_i = 1'b0, cpol_i = 1'b0, cpha_i = 1'b0;
  logic cmd_valid_i = 1'b0, tx_valid_i = 1'b0, rx_ready_i = 1'b0, err_clear_i = 1'b0;
  logic [1:0] target_type_i = 2'h0;
  logic [3:0] sel_i = 4'hF, cmd_len_i = 4'h0;
  logic [7:0] cmd_opcode_i = 8'h00, tx_data_i = 8'h00;
  wire logic cmd_ready_o, tx_ready_o, rx_valid_o, cmd_err_o, busy_o, sck_o, mosi_o, miso_i;
  wire logic [3:0] ss_n_o;
  wire logic [7:0] rx_data_o;
  logic [31:0] seed = 32'haab9_c874;
  logic [7:0] txq[$], exq[$], sent[$];
  logic [7:0] ops[6] = '{8'h03, 8'h3B, 8'h6B, 8'h9B, 8'h2C, 8'h5C};
  logic err_exp = 1'b0, hold = 1'b0;
  int n_fail = 0, n_checks = 0, cyc = 0;
  spi_dual_master i_dut (.*);
  spi_flash_model i_flash (.cpol_i(cpol_i), .cpha_i(cpha_i), .sck_i(sck_o), .ss_n_i(&ss_n_o), .mosi_i(mosi_o),
    .miso_o(miso_i));
  always #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic allowed(input logic [7:0] op, input logic [1:0] tgt);
    if (op inside {8'h32, 8'h34, 8'h38, 8'h3E, 8'h6B, 8'h6C, 8'hEB, 8'hEC, 8'hE7, 8'hF5, 8'hAF}) return 1'b0;
    if (op inside {8'h96, 8'h9B, 8'hE1, 8'hFF}) return 1'b0;
    if (op inside {8'h28, 8'h29, 8'h2D, 8'h2C, 8'hC4}) return tgt == 2'h2;
    if (op inside {8'h21, 8'h5C}) return tgt == 2'h3;
    return 1'b1;
  endfunction : allowed
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  // Receiver stalls one cycle in four so the two-entry buffer is exercised
  always @(posedge clk_i) begin
    cyc++;
    if (tx_valid_i && tx_ready_o) void'(txq.pop_front());
    tx_valid_i <= txq.size() != 0;
    tx_data_i <= txq.size() != 0 ? txq[0] : 8'h00;
    if (rx_valid_o === 1'b1 && rx_ready_i) check("rx_data", exq.size() ? exq.pop_front() : 9'h100, rx_data_o);
    rx_ready_i <= !hold && rnd() % 4 != 0;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic issue(input logic [7:0] op, input int len, input logic [1:0] tgt, input logic [1:0] m);
    @(posedge clk_i);
    {cpol_i, cpha_i} <= m;
    cmd_opcode_i <= op;
    cmd_len_i <= 4'(len);
    target_type_i <= tgt;
    sel_i <= ~(4'h1 << (rnd() % 4));
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    check("cmd_ready", 1'b1, cmd_ready_o);
    cmd_valid_i <= 1'b0;
  endtask : issue
  task automatic frame(input logic [7:0] op, input int len, input logic [1:0] tgt, input logic [1:0] m);
    int e0;
    logic [7:0] b;
    logic [7:0] prev;
    e0 = i_flash.n_edges;
    i_flash.got.delete();
    sent.delete();
    prev = op;
    if (allowed(op, tgt)) begin
      sent.push_back(op);
      for (int i = 0; i < len; i++) begin
        b = 8'(rnd());
        txq.push_back(b);
        sent.push_back(b);
        exq.push_back(prev);
        prev = b;
      end
    end else begin
      err_exp = 1'b1;
    end
    issue(op, len, tgt, m);
    @(posedge clk_i);
    for (int t = 0; t < 4000 && busy_o !== 1'b0; t++) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
    check("ss_n", 4'hF, ss_n_o);
    check("sck_idle", m[1], sck_o);
    check("edges", 16 * sent.size(), i_flash.n_edges - e0);
    check("cmd_err", err_exp, cmd_err_o);
    check("rx_left", 0, exq.size());
    check("bytes", sent.size(), i_flash.got.size());
    foreach (sent[i]) if (i < i_flash.got.size()) check("mosi", sent[i], i_flash.got[i]);
  endtask : frame
  initial begin
    repeat (12) @(posedge clk_i);
    check("ss_rst", 4'hF, ss_n_o);
    check("sck_rst", 1'b0, sck_o);
    check("err_rst", 1'b0, cmd_err_o);
    nrst_i <= 1'b1;
    for (int m = 0; m < 4; m++) frame(8'h03, 3, 2'(rnd()), 2'(m));
    foreach (ops[i]) for (int t = 0; t < 4; t++) frame(ops[i], rnd() % 3, 2'(t), 2'(rnd()));
    @(posedge clk_i);
    err_clear_i <= 1'b1;
    @(posedge clk_i);
    err_clear_i <= 1'b0;
    err_exp = 1'b0;
    @(posedge clk_i);
    check("err_clear", 1'b0, cmd_err_o);
    hold = 1'b1;
    fork
      frame(8'h03, 5, 2'h1, 2'h0);
      begin
        repeat (1500) @(posedge clk_i);
        check("stall_tx", 1'b0, tx_ready_o);
        check("stall_rx", 1'b1, rx_valid_o);
        check("stall_busy", 1'b1, busy_o);
        hold = 1'b0;
      end
    join
    frame(8'h6B, 0, 2'h0, 2'h0);
    issue(8'h0B, 2, 2'h0, 2'h3);
    repeat (300) @(posedge clk_i);
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    err_exp = 1'b0;
    repeat (2) @(posedge clk_i);
    check("srst_ss", 4'hF, ss_n_o);
    check("srst_busy", 1'b0, busy_o);
    check("srst_err", 1'b0, cmd_err_o);
    check("srst_sck", 1'b0, sck_o);
    frame(8'h05, 1, 2'h0, 2'h0);
    stop_test();
  end
endmodule : spi_dual_master_tb
`default_nettype wire
